// ===== hdl/codec_pkg.sv
`default_nettype none
package codec_pkg;

    localparam int BYTE_W = 8;
    localparam int CHAR_W = 10;
    localparam int X_W = 5;
    localparam int Y_W = 3;
    localparam int X_COUNT = 1 << X_W;
    localparam int Y_COUNT = 1 << Y_W;
    localparam int I_POS = 4;
    localparam int COMMA_W = 7;

    localparam logic RD_NEG = 1'b0;
    localparam logic RD_POS = 1'b1;

    // 6-bit codes (abcdei) for the negative column, entry 31 first
    localparam logic [X_COUNT-1:0][5:0] SIX_NEG = {
        6'h2b, 6'h1e, 6'h2e, 6'h0e, 6'h36, 6'h16, 6'h26, 6'h33,
        6'h3a, 6'h1a, 6'h2a, 6'h0b, 6'h32, 6'h13, 6'h23, 6'h1b,
        6'h17, 6'h1c, 6'h2c, 6'h0d, 6'h34, 6'h15, 6'h25, 6'h39,
        6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2d, 6'h1d, 6'h27};
    // 4-bit codes (fghj) after a negative 6-bit sub-block, entry 7 first
    localparam logic [Y_COUNT-1:0][3:0] FOUR_NEG = {
        4'he, 4'h6, 4'ha, 4'hd, 4'hc, 4'h5, 4'h9, 4'hb};
    localparam logic [3:0] ALT7_NEG = 4'h7;
    localparam logic [5:0] K28_SIX_NEG = 6'h0f;
    localparam logic [X_W-1:0] K28_X = 5'h1c;
    localparam logic [Y_W-1:0] Y7 = 3'h7;
    localparam logic [X_COUNT-1:0] A7_NEG_MASK = 32'h0016_0000;
    localparam logic [X_COUNT-1:0] A7_POS_MASK = 32'h0000_6800;
    localparam logic [X_COUNT-1:0] K_X7_MASK = 32'h6880_0000;
    localparam logic [Y_COUNT-1:0] BAL_Y_MASK = 8'h66;

    localparam logic [5:0] SIX_TIE_POS = 6'h07;
    localparam logic [5:0] SIX_TIE_NEG = 6'h38;
    localparam logic [3:0] FOUR_TIE_POS = 4'h3;
    localparam logic [3:0] FOUR_TIE_NEG = 4'hc;
    localparam int SIX_HALF = 3;
    localparam int FOUR_HALF = 2;
    localparam int CHAR_HALF = 5;
    localparam int CHAR_ONES_MIN = 4;
    localparam int CHAR_ONES_MAX = 6;

    localparam logic [BYTE_W-1:0] FORCE_A_BYTE = 8'he1;
    localparam logic [BYTE_W-1:0] FORCE_B_BYTE = 8'he2;
    localparam logic [BYTE_W-1:0] K28P5_BYTE = 8'hbc;
    localparam logic [CHAR_W-1:0] K28P5_NEG = 10'h0fa;
    localparam logic [CHAR_W-1:0] K28P5_POS = 10'h305;
    localparam logic [COMMA_W-1:0] COMMA_POS = 7'h1f;
    localparam logic [COMMA_W-1:0] COMMA_NEG = 7'h60;

    typedef struct packed {
        logic special;
        logic [BYTE_W-1:0] data;
    } byte_s;

    typedef struct packed {
        byte_s b;
        logic violation;
    } decode_s;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic tx_rd;
        logic rx_rd;
        logic rx_valid;
        byte_s rx_byte;
        logic rx_violation;
        logic rx_comma;
    } codec_state_s;

endpackage
`default_nettype wire

// ===== hdl/char_serializer.sv
`timescale 1ns/1ps
`default_nettype none
module char_serializer #(
    parameter int CHAR_W = codec_pkg::CHAR_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // parallel side
    input wire logic load,
    input wire logic [CHAR_W-1:0] char_in,
    output logic ready,
    // line
    output logic ser_out
);
    localparam int CNT_W = $clog2(CHAR_W + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(CHAR_W);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(1);

    if (CHAR_W < 2) begin : g_bad_width
        $error("char_serializer needs at least two bits");
    end

    typedef struct packed {
        logic [CHAR_W-1:0] shift;
        logic [CNT_W-1:0] cnt;
    } ser_state_s;

    ser_state_s st_q;
    ser_state_s st_d;

    always_comb begin
        st_d = st_q;
        if (st_q.cnt != '0) begin
            st_d.shift = {st_q.shift[CHAR_W-2:0], 1'b0};
            st_d.cnt = st_q.cnt - CNT_LAST;
        end
        // reload on the last bit so characters follow with no idle bit
        if (load) begin
            st_d.shift = char_in;
            st_d.cnt = CNT_FULL;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ready = (st_q.cnt <= CNT_LAST);
    assign ser_out = st_q.shift[CHAR_W-1];
endmodule
`default_nettype wire

// ===== hdl/char_deserializer.sv
`timescale 1ns/1ps
`default_nettype none
module char_deserializer #(
    parameter int CHAR_W = codec_pkg::CHAR_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // line
    input wire logic ser_in,
    // parallel side
    output logic [CHAR_W-1:0] word,
    output logic strobe
);
    localparam int CNT_W = $clog2(CHAR_W);
    localparam logic [CNT_W-1:0] CNT_END = CNT_W'(CHAR_W - 1);
    localparam logic [CNT_W-1:0] CNT_STEP = CNT_W'(1);

    if (CHAR_W < 2) begin : g_bad_width
        $error("char_deserializer needs at least two bits");
    end

    typedef struct packed {
        logic [CHAR_W-1:0] sh;
        logic [CNT_W-1:0] cnt;
        logic [CHAR_W-1:0] word;
        logic strobe;
    } des_state_s;

    des_state_s st_q;
    des_state_s st_d;

    // no framing: boundaries count from reset release
    always_comb begin
        st_d = st_q;
        st_d.sh = {st_q.sh[CHAR_W-2:0], ser_in};
        st_d.strobe = 1'b0;
        if (st_q.cnt == CNT_END) begin
            st_d.word = {st_q.sh[CHAR_W-2:0], ser_in};
            st_d.strobe = 1'b1;
            st_d.cnt = '0;
        end else begin
            st_d.cnt = st_q.cnt + CNT_STEP;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign word = st_q.word;
    assign strobe = st_q.strobe;
endmodule
`default_nettype wire

// ===== hdl/codec_8b10b.sv
`timescale 1ns/1ps
`default_nettype none
module codec_8b10b (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // transmit byte side
    input wire logic tx_valid,
    input wire codec_pkg::byte_s tx_byte,
    output logic tx_ready,
    // serial line
    output logic ser_out,
    input wire logic ser_in,
    // receive byte side
    output logic rx_valid,
    output codec_pkg::byte_s rx_byte,
    output logic rx_violation,
    output logic rx_comma,
    // disparity state
    output logic tx_disparity,
    output logic rx_disparity
);
    ////////////////////////////////////////////////////////////////////////////
    // code functions

    function automatic logic sub6(input logic rd, input logic [5:0] s);
        if (($countones(s) > codec_pkg::SIX_HALF) || (s == codec_pkg::SIX_TIE_POS)) begin
            return codec_pkg::RD_POS;
        end
        if (($countones(s) < codec_pkg::SIX_HALF) || (s == codec_pkg::SIX_TIE_NEG)) begin
            return codec_pkg::RD_NEG;
        end
        return rd;
    endfunction

    function automatic logic sub4(input logic rd, input logic [3:0] f);
        if (($countones(f) > codec_pkg::FOUR_HALF) || (f == codec_pkg::FOUR_TIE_POS)) begin
            return codec_pkg::RD_POS;
        end
        if (($countones(f) < codec_pkg::FOUR_HALF) || (f == codec_pkg::FOUR_TIE_NEG)) begin
            return codec_pkg::RD_NEG;
        end
        return rd;
    endfunction

    // first sub-block starts from the old value, second from the first
    function automatic logic char_disp(input logic rd, input logic [codec_pkg::CHAR_W-1:0] c);
        return sub4(sub6(rd, c[9:4]), c[3:0]);
    endfunction

    // abcdei from EDCBA and the K28 flag; the positive column flips unbalanced codes
    function automatic logic [5:0] six_code(input logic [4:0] x, input logic rd, input logic k28);
        logic [5:0] c;
        c = k28 ? codec_pkg::K28_SIX_NEG : codec_pkg::SIX_NEG[x];
        if (rd && (($countones(c) != codec_pkg::SIX_HALF) || (c == codec_pkg::SIX_TIE_NEG))) begin
            c = ~c;
        end
        return c;
    endfunction

    // fghj from HGF, steered by the mid-character disparity
    function automatic logic [3:0] four_code(input logic [2:0] y, input logic rdm, input logic k,
                                             input logic [4:0] x);
        logic alt;
        logic inv;
        logic [3:0] c;
        alt = (y == codec_pkg::Y7) && (k || (!rdm && codec_pkg::A7_NEG_MASK[x]) ||
                                      (rdm && codec_pkg::A7_POS_MASK[x]));
        c = alt ? codec_pkg::ALT7_NEG : codec_pkg::FOUR_NEG[y];
        // balanced specials flip the other way so the comma stays unique
        inv = codec_pkg::BAL_Y_MASK[y] ? (k && !rdm) : rdm;
        if (inv) begin
            c = ~c;
        end
        return c;
    endfunction

    function automatic logic [codec_pkg::CHAR_W-1:0] encode(input codec_pkg::byte_s b, input logic rd);
        logic start;
        logic k;
        logic rdm;
        logic [4:0] x;
        logic [2:0] y;
        logic [5:0] s;
        logic [3:0] f;
        start = rd;
        k = b.special;
        x = b.data[4:0];
        y = b.data[7:5];
        if (k && (b.data == codec_pkg::FORCE_A_BYTE)) begin
            start = codec_pkg::RD_NEG;
            x = codec_pkg::K28P5_BYTE[4:0];
            y = codec_pkg::K28P5_BYTE[7:5];
        end else if (k && (b.data == codec_pkg::FORCE_B_BYTE)) begin
            start = codec_pkg::RD_POS;
            x = codec_pkg::K28P5_BYTE[4:0];
            y = codec_pkg::K28P5_BYTE[7:5];
        end else if (k && !((x == codec_pkg::K28_X) || ((y == codec_pkg::Y7) && codec_pkg::K_X7_MASK[x]))) begin
            // undefined specials would break the comma property, send a comma instead
            x = codec_pkg::K28P5_BYTE[4:0];
            y = codec_pkg::K28P5_BYTE[7:5];
        end
        s = six_code(x, start, k && (x == codec_pkg::K28_X));
        rdm = sub6(start, s);
        f = four_code(y, rdm, k, x);
        return {s, f};
    endfunction

    function automatic codec_pkg::decode_s decode(input logic [codec_pkg::CHAR_W-1:0] w, input logic rd);
        codec_pkg::decode_s r;
        logic found6;
        logic found4;
        logic k6;
        logic kk;
        logic rdm;
        logic [4:0] x;
        logic [2:0] y;
        found6 = 1'b0;
        found4 = 1'b0;
        k6 = 1'b0;
        kk = 1'b0;
        x = '0;
        y = '0;
        // search only the column of the current disparity
        for (int i = 0; i < codec_pkg::X_COUNT; i++) begin
            if (six_code(5'(i), rd, 1'b0) == w[9:4]) begin
                found6 = 1'b1;
                x = 5'(i);
            end
        end
        if (six_code(codec_pkg::K28_X, rd, 1'b1) == w[9:4]) begin
            found6 = 1'b1;
            k6 = 1'b1;
            x = codec_pkg::K28_X;
        end
        rdm = sub6(rd, w[9:4]);
        for (int j = 0; j < codec_pkg::Y_COUNT; j++) begin
            if (!k6 && (four_code(3'(j), rdm, 1'b0, x) == w[3:0])) begin
                found4 = 1'b1;
                y = 3'(j);
                kk = 1'b0;
            end
            if ((k6 || ((3'(j) == codec_pkg::Y7) && codec_pkg::K_X7_MASK[x])) &&
                (four_code(3'(j), rdm, 1'b1, x) == w[3:0])) begin
                found4 = 1'b1;
                y = 3'(j);
                kk = 1'b1;
            end
        end
        r.b.special = kk;
        r.b.data = {y, x};
        r.violation = !(found6 && found4);
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    codec_pkg::codec_state_s st_q;
    codec_pkg::codec_state_s st_d;
    logic srst_n;
    logic ser_ready;
    logic tx_fire;
    logic [codec_pkg::CHAR_W-1:0] tx_char;
    logic [codec_pkg::CHAR_W-1:0] rx_word;
    logic rx_strobe;
    logic tx_a_bit;
    logic tx_i_bit;
    logic tx_forced;
    codec_pkg::decode_s rx_dec;

    assign srst_n = st_q.rst_sync[1];
    assign tx_ready = ser_ready && srst_n;
    assign tx_fire = tx_valid && tx_ready;
    assign tx_char = encode(tx_byte, st_q.tx_rd);
    assign tx_a_bit = tx_char[codec_pkg::CHAR_W-1];
    assign tx_i_bit = tx_char[codec_pkg::I_POS];
    assign tx_forced = tx_byte.special && ((tx_byte.data == codec_pkg::FORCE_A_BYTE) ||
                                           (tx_byte.data == codec_pkg::FORCE_B_BYTE));
    assign rx_dec = decode(rx_word, st_q.rx_rd);

    always_comb begin
        st_d = st_q;
        st_d.rst_sync = {st_q.rst_sync[0], 1'b1};
        st_d.rx_valid = 1'b0;
        if (!srst_n) begin
            st_d.tx_rd = codec_pkg::RD_NEG;
            st_d.rx_rd = codec_pkg::RD_NEG;
            st_d.rx_byte = '0;
            st_d.rx_violation = 1'b0;
            st_d.rx_comma = 1'b0;
        end else begin
            if (tx_fire) begin
                st_d.tx_rd = char_disp(st_q.tx_rd, tx_char);
            end
            if (rx_strobe) begin
                st_d.rx_valid = 1'b1;
                st_d.rx_byte = rx_dec.b;
                st_d.rx_violation = rx_dec.violation;
                st_d.rx_comma = (rx_word[9:3] == codec_pkg::COMMA_POS) ||
                                (rx_word[9:3] == codec_pkg::COMMA_NEG);
                st_d.rx_rd = char_disp(st_q.rx_rd, rx_word);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // line side

    char_serializer #(.CHAR_W(codec_pkg::CHAR_W)) u_ser (
        .clk(clk),
        .rst_n(srst_n),
        .load(tx_fire),
        .char_in(tx_char),
        .ready(ser_ready),
        .ser_out(ser_out)
    );

    char_deserializer #(.CHAR_W(codec_pkg::CHAR_W)) u_des (
        .clk(clk),
        .rst_n(srst_n),
        .ser_in(ser_in),
        .word(rx_word),
        .strobe(rx_strobe)
    );

    assign rx_valid = st_q.rx_valid;
    assign rx_byte = st_q.rx_byte;
    assign rx_violation = st_q.rx_violation;
    assign rx_comma = st_q.rx_comma;
    assign tx_disparity = st_q.tx_rd;
    assign rx_disparity = st_q.rx_rd;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_tx_char_gap: assert property (@(posedge clk) disable iff (!srst_n)
        tx_fire |=> !tx_ready [*8])
        else $error("transmitter took a byte before its character was out");

    a_tx_first_bit: assert property (@(posedge clk) disable iff (!srst_n)
        tx_fire |=> (ser_out == $past(tx_a_bit)))
        else $error("bit a was not sent first");

    a_tx_i_slot: assert property (@(posedge clk) disable iff (!srst_n)
        tx_fire |-> ##6 (ser_out == $past(tx_i_bit, 6)))
        else $error("bit i not in sixth slot");

    a_tx_balance: assert property (@(posedge clk) disable iff (!srst_n)
        tx_fire |-> ($countones(tx_char) >= codec_pkg::CHAR_ONES_MIN) &&
                    ($countones(tx_char) <= codec_pkg::CHAR_ONES_MAX))
        else $error("sent character has illegal weight");

    a_tx_column: assert property (@(posedge clk) disable iff (!srst_n)
        (tx_fire && !tx_forced && ($countones(tx_char) != codec_pkg::CHAR_HALF)) |->
        (($countones(tx_char) > codec_pkg::CHAR_HALF) == (st_q.tx_rd == codec_pkg::RD_NEG)))
        else $error("unbalanced character sent in wrong column");

    a_tx_rd_pos: assert property (@(posedge clk) disable iff (!srst_n)
        (tx_fire && ($countones(tx_char) > codec_pkg::CHAR_HALF)) |=> (tx_disparity == codec_pkg::RD_POS))
        else $error("disparity not positive after heavy character");

    a_tx_rd_neg: assert property (@(posedge clk) disable iff (!srst_n)
        (tx_fire && ($countones(tx_char) < codec_pkg::CHAR_HALF)) |=> (tx_disparity == codec_pkg::RD_NEG))
        else $error("disparity not negative after light character");

    a_tx_forced_a: assert property (@(posedge clk) disable iff (!srst_n)
        (tx_fire && tx_byte.special && (tx_byte.data == codec_pkg::FORCE_A_BYTE)) |->
        (tx_char == codec_pkg::K28P5_NEG))
        else $error("forcing code a gave wrong character");

    a_rx_weight_viol: assert property (@(posedge clk) disable iff (!srst_n)
        (rx_strobe && (($countones(rx_word) < codec_pkg::CHAR_ONES_MIN) ||
                       ($countones(rx_word) > codec_pkg::CHAR_ONES_MAX))) |=> (rx_valid && rx_violation))
        else $error("illegal-weight character not flagged");

    // a heavy fghj ends positive whatever came before, valid character or not
    a_rx_rd_always: assert property (@(posedge clk) disable iff (!srst_n)
        (rx_strobe && ($countones(rx_word[3:0]) > codec_pkg::FOUR_HALF)) |=>
        (rx_disparity == codec_pkg::RD_POS))
        else $error("receive disparity not updated by character");

    a_rx_char_rate: assert property (@(posedge clk) disable iff (!srst_n)
        rx_valid |=> !rx_valid [*8])
        else $error("receive characters closer than ten bits");
endmodule
`default_nettype wire

// ===== testbench/remote_end.sv
`timescale 1ns/1ps
`default_nettype none
module remote_end (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // line from the device, error injection
    input wire logic line_in,
    input wire logic flip,
    // line back to the device
    output logic line_out
);
    // nine cells put the echo on the receiver's ten-bit boundaries
    logic [8:0] dly_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dly_q <= 9'h0a5;  // mixed pattern, never a quiet copy of the last bit
        end else begin
            dly_q <= {dly_q[7:0], line_in ^ flip};
        end
    end
    assign line_out = dly_q[8];
endmodule
`default_nettype wire

// ===== testbench/tb_codec_8b10b.sv
`timescale 1ns/1ps
`default_nettype none
module tb_codec_8b10b;
    localparam logic [5:0] SIX [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
        6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    localparam logic [3:0] FOUR [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
    localparam logic [3:0] K28_4 [8] = '{4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'ha, 4'h6, 4'h8};
    localparam logic [4:0] KX7 [4] = '{5'h17, 5'h1b, 5'h1d, 5'h1e};
    logic clk, rst_n, tx_valid, tx_ready, ser_out, ser_in, rx_valid, rx_violation, rx_comma;
    logic tx_disparity, rx_disparity, flip, trd, rrd, tcol;
    codec_pkg::byte_s tx_byte, rx_byte, rb;
    int seed, failures, n_tests, r, ecnt, rn, tn;
    logic [9:0] tsh, rsh, dv;
    logic [10:0] txq [$];
    logic [11:0] rxq [$];

    codec_8b10b dut (.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_ready(tx_ready), .ser_out(ser_out), .ser_in(ser_in), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_violation(rx_violation), .rx_comma(rx_comma),
        .tx_disparity(tx_disparity), .rx_disparity(rx_disparity));
    remote_end far (.clk(clk), .rst_n(rst_n), .line_in(ser_out), .flip(flip), .line_out(ser_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    function automatic logic sub_rd(input logic [5:0] v, input int w, input logic rd);
        int n;
        n = $countones(v);
        if (2 * n > w) return 1'b1;
        if (2 * n < w) return 1'b0;
        if ((w == 6 && v == 6'h07) || (w == 4 && v == 6'h03)) return 1'b1;
        if ((w == 6 && v == 6'h38) || (w == 4 && v == 6'h0c)) return 1'b0;
        return rd;
    endfunction

    function automatic logic char_rd(input logic [9:0] c, input logic rd);
        return sub_rd({2'h0, c[3:0]}, 4, sub_rd(c[9:4], 6, rd));
    endfunction

    function automatic logic [9:0] enc(input codec_pkg::byte_s b, input logic rd);
        logic [4:0] x;
        logic [2:0] y;
        logic [5:0] s;
        logic [3:0] f;
        logic r6;
        logic [9:0] k;
        x = b.data[4:0];
        y = b.data[7:5];
        if (b.special) begin
            if (b.data == 8'he1) return 10'h0fa;
            if (b.data == 8'he2) return 10'h305;
            if (!(x == 5'h1c || (y == 3'h7 && x inside {5'h17, 5'h1b, 5'h1d, 5'h1e}))) begin
                x = 5'h1c;
                y = 3'h5;
            end
            k = {(x == 5'h1c) ? 6'h0f : SIX[x], (x == 5'h1c) ? K28_4[y] : 4'h8};
            return rd ? ~k : k;
        end
        s = SIX[x];
        if (rd && ($countones(s) != 3 || x == 5'h07)) s = ~s;
        r6 = sub_rd(s, 6, rd);
        f = FOUR[y];
        // alternate .7 avoids a run of five equal bits across the sub-block seam
        if (y == 3'h7 && ((!r6 && x inside {5'h11, 5'h12, 5'h14}) || (r6 && x inside {5'h0b, 5'h0d, 5'h0e})))
            f = 4'h7;
        if (r6 && ($countones(f) != 2 || y == 3'h3)) f = ~f;
        return {s, f};
    endfunction

    function automatic codec_pkg::byte_s kbyte(input int k);
        return (k < 8) ? {1'b1, k[2:0], 5'h1c} : {1'b1, 3'h7, KX7[k-8]};
    endfunction

    // brute search of the column: slow but shares nothing with a real decoder
    function automatic logic [9:0] dec(input logic [9:0] c, input logic rd);
        codec_pkg::byte_s b;
        for (int i = 0; i < 268; i++) begin
            b = (i < 256) ? {1'b0, i[7:0]} : kbyte(i - 256);
            if (enc(b, rd) === c) return {1'b1, b};
        end
        return 10'h000;
    endfunction

    ////////////////////////////////////////////////////////////////
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_char(input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: character %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input codec_pkg::byte_s got, input codec_pkg::byte_s exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // tx_valid stays high, so the stream never gaps and receive framing holds
    task automatic send(input codec_pkg::byte_s b, input logic fl);
        tx_byte <= b;
        @(posedge clk iff tx_ready === 1'b1);
        if (fl) begin
            repeat (8) @(posedge clk);
            flip <= 1'b1;
            @(posedge clk);
            flip <= 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (tcol) begin
            tsh = {tsh[8:0], ser_out};
            tn++;
            if (tn == 10) begin
                tn = 0;
                chk_char(tsh, txq[0][9:0]);
                chk_bit(tx_disparity, txq[0][10]);
                void'(txq.pop_front());
            end
        end
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            tsh = enc(tx_byte, trd);
            trd = char_rd(tsh, trd);
            txq.push_back({trd, tsh});
            tcol = 1'b1;
        end
        ecnt = rst_n ? ecnt + 1 : 0;
        if (ecnt >= 3) begin
            rsh = {rsh[8:0], ser_in};
            rn++;
            if (rn == 10) begin
                rn = 0;
                dv = dec(rsh, rrd);
                rrd = char_rd(rsh, rrd);
                rxq.push_back({!dv[9], (rsh[9:3] == 7'h1f) || (rsh[9:3] == 7'h60), rrd, dv[8:0]});
            end
        end
        if (rx_valid === 1'b1) begin
            chk_bit(rx_violation, rxq[0][11]);
            chk_bit(rx_comma, rxq[0][10]);
            chk_bit(rx_disparity, rxq[0][9]);
            if (!rxq[0][11]) chk_byte(rx_byte, rxq[0][8:0]);
            void'(rxq.pop_front());
        end
    end

    initial begin
        #200000;
        failures++;
        $display("wrong value at %0t: run did not finish", $time);
        wrap_up;
    end

    initial begin
        seed = 84;
        {failures, n_tests, ecnt, rn, tn} = '0;
        {trd, rrd, tcol, flip, tx_valid, rst_n} = '0;
        tx_byte = '0;
        repeat (3) @(posedge clk);
        chk_bit(tx_ready | ser_out | rx_valid, 1'b0);
        chk_bit(tx_disparity | rx_disparity, 1'b0);
        rst_n <= 1'b1;
        @(posedge clk);
        tx_valid <= 1'b1;
        for (int i = 0; i < 4; i++) send({1'b1, 6'h38, i[1] ? 2'h2 : 2'h1}, 1'b0);
        send(9'h035, 1'b1);
        send(9'h04a, 1'b0);
        send(9'h0b7, 1'b0);
        for (int d = 0; d < 256; d++) send({1'b0, d[7:0]}, 1'b0);
        for (int k = 0; k < 12; k++) send(kbyte(k), 1'b0);
        send(9'h100, 1'b0);
        repeat (300) begin
            r = $random(seed);
            rb = {r[2:0] == 3'h0, r[12:5]};
            if (rb.special && r[3]) rb.data[4:0] = 5'h1c;
            send(rb, 1'b0);
        end
        repeat (40) @(posedge clk);
        wrap_up;
    end
endmodule
`default_nettype wire
